// *** rtl/msc_muting.v ***
// Muting sequence controller top level.
// Behaviour
// - Concurrent: pair occupied within window mutes
// - Start only when sensors clear, curtain free
// - Timeout ends muting at once
// - Muting always enabled unless enable option
// - Enable/disable: cycle needs enable rising edge
// - Enable/disable: falling edge cancels muting
// - Enable-only: enable cannot stop muting
// - Concurrent: pairs accepted in set direction
// - Curtain or third-sensor clear closes muting
// - Blind time holds curtain high after curtain or L mode close
// - Reject second sensor later than sensor time
// - Optional minimum 150 ms pair separation
// - L mode ends when opening cleared
// - L mode end time after first release
// - Sequential needs two sensors in order
// - Sequential honours direction setting
// - T mode ends on either sensor release
`timescale 1ns/1ps
`include "msc_regs.vh"
module msc_muting #(
   parameter TICK_DIV = `MSC_CLK_HZ / 1000 * `MSC_TICK_MS
) (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Configuration
   input wire [1:0] cfg_mode,
   input wire [1:0] cfg_direction,
   input wire cfg_with_enable,
   input wire cfg_enable_type,
   input wire cfg_sensor_close,
   input wire cfg_blind_on,
   input wire cfg_min_sensor_on,
   input wire cfg_timeout_unlimited,
   input wire [15:0] cfg_timeout_ticks,
   input wire [15:0] cfg_sensor_ticks,
   input wire [15:0] cfg_end_ticks,
   input wire [15:0] cfg_blind_ticks,
   // Sensors and curtain
   input wire entry_sensor_a,
   input wire entry_sensor_b,
   input wire exit_sensor_a,
   input wire exit_sensor_b,
   input wire curtain_in,
   input wire enable_in,
   // Outputs
   output reg muted_out,
   output reg muting_active,
   output reg [5:0] state_out
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   // Idle: waiting for a clean start condition.
   localparam [5:0] ST_IDLE = 6'b000001;
   // Pair: first sensor of a pair seen, waiting for its partner.
   localparam [5:0] ST_PAIR = 6'b000010;
   // Sequence: walking the first two sensors in passage order.
   localparam [5:0] ST_SEQ = 6'b000100;
   // Mute: curtain bypassed until the closing condition.
   localparam [5:0] ST_MUTE = 6'b001000;
   // Tail: refused or aborted cycle, held until the sensors clear.
   localparam [5:0] ST_TAIL = 6'b010000;
   // Blind: cycle closed, curtain still treated as free.
   localparam [5:0] ST_BLIND = 6'b100000;
   // Longest pair separation that is still refused, in ticks.
   localparam [15:0] MIN_TICKS = `MSC_MIN_SENSOR_TICKS;

   // Time base and the two running timers.
   wire tick;
   wire [15:0] t_step;
   wire [15:0] t_cycle;

   // Sequence state.
   reg [5:0] state_reg;
   reg [5:0] state_next;
   reg rst_step;
   reg rst_cycle;

   // Enable edge detection and arming.
   reg en_d_reg;
   reg armed_reg;
   reg armed_next;

   // Passage direction and sequential progress.
   reg down_reg;
   reg down_next;
   reg [1:0] seq_idx_reg;
   reg [1:0] seq_idx_next;

   // Release tracking: ready flag while idle, pair released while muted.
   reg released_reg;
   reg released_next;

   // L mode: the first sensor of the pair has released.
   reg first_rel_reg;
   reg first_rel_next;

   // ----------------------------------------
   // Time base and timers
   // ----------------------------------------
   msc_tick #(.DIV(TICK_DIV)) u_tick (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(tick)
   );
   msc_timer u_step (
      .clk_sys(clk_sys),
      .reset(reset),
      .restart(rst_step),
      .tick(tick),
      .count(t_step)
   );
   msc_timer u_cycle (
      .clk_sys(clk_sys),
      .reset(reset),
      .restart(rst_cycle),
      .tick(tick),
      .count(t_cycle)
   );

   // ----------------------------------------
   // Sensor views
   // ----------------------------------------
   // L and T variants ignore the exit sensors entirely.
   wire two_only = (cfg_mode == `MSC_MODE_L) || (cfg_mode == `MSC_MODE_T);
   wire [3:0] sens = {exit_sensor_b, exit_sensor_a, entry_sensor_b, entry_sensor_a};
   wire all_clear = two_only ? ~(entry_sensor_a | entry_sensor_b) : ~|sens;

   // Pair summaries.
   wire entry_any = entry_sensor_a | entry_sensor_b;
   wire entry_both = entry_sensor_a & entry_sensor_b;
   wire exit_any = exit_sensor_a | exit_sensor_b;
   wire exit_both = exit_sensor_a & exit_sensor_b;

   // Direction permits; the two-sensor variants only know the entry pair.
   wire up_ok = cfg_direction != `MSC_DIR_DOWN;
   wire dn_ok = (cfg_direction != `MSC_DIR_UP) && !two_only;

   // Enable edges; the delay register resets low, the idle level of the pin.
   wire en_rise = enable_in & ~en_d_reg;
   wire en_fall = ~enable_in & en_d_reg;

   // In enable/disable mode a falling edge aborts whatever is in progress.
   wire en_abort = cfg_with_enable && cfg_enable_type == `MSC_EN_DISABLE && en_fall;
   wire permit = !cfg_with_enable || armed_reg;
   wire timed_out = !cfg_timeout_unlimited && t_cycle >= cfg_timeout_ticks;
   // Sequential order index maps onto the sensor vector in either direction.
   wire [1:0] seq_pos = down_reg ? 2'd3 - seq_idx_reg : seq_idx_reg;
   wire [3:0] seq_hold = down_reg ? (4'b1111 << (2'd3 - seq_idx_reg)) : (4'b1111 >> (2'd3 - seq_idx_reg));
   wire pair_done = down_reg ? exit_both : entry_both;
   wire third_clear = down_reg ? !entry_sensor_b : !exit_sensor_a;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         en_d_reg <= 1'b0;
         armed_reg <= 1'b0;
         down_reg <= 1'b0;
         seq_idx_reg <= 2'd0;
         released_reg <= 1'b0;
         first_rel_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         en_d_reg <= enable_in;
         armed_reg <= armed_next;
         down_reg <= down_next;
         seq_idx_reg <= seq_idx_next;
         released_reg <= released_next;
         first_rel_reg <= first_rel_next;
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   always @* begin
      // Defaults hold every register, so each state names only what it changes.
      state_next = state_reg;
      down_next = down_reg;
      seq_idx_next = seq_idx_reg;
      released_next = released_reg;
      first_rel_next = first_rel_reg;
      rst_step = 1'b0;
      rst_cycle = 1'b0;
      armed_next = armed_reg;

      // A rising edge arms one cycle; the enable must fall again to re-arm.
      if (en_rise) begin
         armed_next = 1'b1;
      end

      case (state_reg)
         // Idle keeps both timers at zero. The ready flag records that the last
         // sample saw every used sensor clear and the curtain free, so the first
         // sensor of a passage is accepted only on the sample right after that.
         ST_IDLE: begin
            rst_step = 1'b1;
            rst_cycle = 1'b1;
            first_rel_next = 1'b0;
            seq_idx_next = 2'd0;
            released_next = all_clear && curtain_in;
            if (released_reg && curtain_in && permit) begin
               if (entry_any && up_ok) begin
                  down_next = 1'b0;
                  released_next = 1'b0;
                  state_next = (cfg_mode == `MSC_MODE_SEQ) ? ST_SEQ : ST_PAIR;
               end else if (exit_any && dn_ok) begin
                  down_next = 1'b1;
                  released_next = 1'b0;
                  state_next = (cfg_mode == `MSC_MODE_SEQ) ? ST_SEQ : ST_PAIR;
               end
            end
         end

         // A pair that completes too late, too early or falls apart is refused.
         ST_PAIR: begin
            if (t_step > cfg_sensor_ticks || !(down_reg ? exit_any : entry_any)) begin
               state_next = ST_TAIL;
            end else if (pair_done) begin
               if (cfg_mode == `MSC_MODE_CONC && cfg_min_sensor_on && t_step <= MIN_TICKS) begin
                  state_next = ST_TAIL;
               end else begin
                  state_next = ST_MUTE;
                  armed_next = 1'b0;
               end
            end
         end

         // Every sensor already passed must stay occupied while the next one is awaited.
         ST_SEQ: begin
            if (!(&(sens | ~seq_hold))) begin
               state_next = ST_TAIL;
            end else if (seq_idx_reg == 2'd1) begin
               state_next = ST_MUTE;
               armed_next = 1'b0;
            end else if (sens[down_reg ? seq_pos - 2'd1 : seq_pos + 2'd1]) begin
               seq_idx_next = seq_idx_reg + 2'd1;
            end
         end

         // Muted: each variant has its own closing condition; the timeout overrides all.
         ST_MUTE: begin
            if (cfg_mode == `MSC_MODE_T) begin
               if (!entry_both) begin
                  state_next = ST_IDLE;
               end
            end else if (cfg_mode == `MSC_MODE_L) begin
               if (!first_rel_reg && !entry_both) begin
                  first_rel_next = 1'b1;
                  rst_step = 1'b1;
               end
               if (first_rel_reg && (t_step >= cfg_end_ticks || (!entry_any && curtain_in))) begin
                  state_next = cfg_blind_on ? ST_BLIND : ST_IDLE;
                  rst_step = 1'b1;
               end
            end else if (cfg_sensor_close) begin
               if (!(down_reg ? entry_any : exit_any) && (down_reg ? exit_any : entry_any)) begin
                  state_next = ST_MUTE;
               end else if (!(down_reg ? exit_any : entry_any) && third_clear) begin
                  state_next = ST_IDLE;
               end
            end else begin
               if (!(down_reg ? exit_any : entry_any)) begin
                  released_next = 1'b1;
               end
               // Closing acts on the very sample that shows the curtain free again,
               // so a rise of the curtain never leaves muting on for an extra cycle.
               if (released_next && curtain_in) begin
                  state_next = cfg_blind_on ? ST_BLIND : ST_IDLE;
                  rst_step = 1'b1;
               end
            end
            if (timed_out) begin
               state_next = ST_TAIL;
            end
         end

         // A refused or aborted cycle can only be left with the gate empty.
         ST_TAIL: begin
            if (all_clear) begin
               state_next = ST_IDLE;
            end
         end

         // Blind time: protruding objects may still block the curtain here.
         ST_BLIND: begin
            if (t_step >= cfg_blind_ticks) begin
               state_next = ST_IDLE;
            end
         end

         // An illegal code can only come from an upset; fall back to idle.
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      // The abort is applied last so that it wins over every state decision taken outside idle and tail.
      if (en_abort) begin
         armed_next = 1'b0;
         if (state_reg != ST_IDLE && state_reg != ST_TAIL) begin
            state_next = ST_TAIL;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         muted_out <= 1'b0;
         muting_active <= 1'b0;
         state_out <= ST_IDLE;
      end else begin
         // Outputs come from the next state so they follow a decision by one cycle only.
         // The unmuted output is the curtain delayed by that same cycle.
         muting_active <= (state_next == ST_MUTE);
         muted_out <= (state_next == ST_MUTE || state_next == ST_BLIND) ? 1'b1 : curtain_in;
         state_out <= state_next;
      end
   end
endmodule

// *** rtl/msc_regs.vh ***
// Constants for the muting sequence controller.
`ifndef MSC_REGS_VH
`define MSC_REGS_VH
// ----------------------------------------
// Logic variants
// ----------------------------------------
`define MSC_MODE_CONC 2'd0
`define MSC_MODE_L 2'd1
`define MSC_MODE_SEQ 2'd2
`define MSC_MODE_T 2'd3
// ----------------------------------------
// Direction codes
// ----------------------------------------
`define MSC_DIR_UP 2'd0
`define MSC_DIR_DOWN 2'd1
`define MSC_DIR_EITHER 2'd2
// ----------------------------------------
// Enable types
// ----------------------------------------
`define MSC_EN_DISABLE 1'b0
`define MSC_EN_ONLY 1'b1
// ----------------------------------------
// Timing: periods in milliseconds and ticks, clock in hertz, timer width in bits
// ----------------------------------------
`define MSC_TICK_MS 10
`define MSC_MIN_SENSOR_MS 150
`define MSC_MIN_SENSOR_TICKS (`MSC_MIN_SENSOR_MS / `MSC_TICK_MS)
`define MSC_CLK_HZ 20000000
`define MSC_TIMER_W 16
`endif

// *** rtl/msc_tick.v ***
// Fixed time base that pulses once per tick period.
`timescale 1ns/1ps
module msc_tick #(
   parameter DIV = 200000
) (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Tick pulse
   output reg tick
);
   reg [31:0] cnt_reg;
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cnt_reg <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (cnt_reg == DIV - 1) begin
         cnt_reg <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule

// *** rtl/msc_timer.v ***
// Tick counter that restarts on demand and saturates.
`timescale 1ns/1ps
`include "msc_regs.vh"
module msc_timer (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Control
   input wire restart,
   input wire tick,
   // Elapsed ticks
   output reg [`MSC_TIMER_W-1:0] count
);
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count <= {`MSC_TIMER_W{1'b0}};
      end else if (restart) begin
         count <= {`MSC_TIMER_W{1'b0}};
      end else if (tick && count != {`MSC_TIMER_W{1'b1}}) begin
         count <= count + 1'b1;
      end
   end
endmodule

// *** test/msc_field.sv ***
// Behavioural muting photo sensors and light curtain.
`timescale 1ns/1ps
module msc_field (
   // Scene picked by the bench
   input wire [4:0] scene,
   // Sensor and curtain lines
   output wire entry_sensor_a,
   output wire entry_sensor_b,
   output wire exit_sensor_a,
   output wire exit_sensor_b,
   output wire curtain_in
);
   // The lines are push-pull and always driven, so no released level exists.
   assign {entry_sensor_a, entry_sensor_b, exit_sensor_a, exit_sensor_b, curtain_in} = scene;
endmodule

// *** test/msc_muting_properties.sv ***
// Concurrent checks on the ports of the muting controller.
`timescale 1ns/1ps
`include "msc_regs.vh"
module msc_muting_props #(
   parameter TICK_DIV = 20
) (
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Watched ports
   input wire [1:0] cfg_mode,
   input wire cfg_with_enable,
   input wire cfg_enable_type,
   input wire cfg_sensor_close,
   input wire cfg_blind_on,
   input wire cfg_timeout_unlimited,
   input wire [15:0] cfg_timeout_ticks,
   input wire entry_sensor_a,
   input wire entry_sensor_b,
   input wire exit_sensor_a,
   input wire exit_sensor_b,
   input wire curtain_in,
   input wire enable_in,
   input wire muted_out,
   input wire muting_active
);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire pair_in = entry_sensor_a & entry_sensor_b;
   wire pair_out = exit_sensor_a & exit_sensor_b;
   reg [31:0] on_cnt_reg;
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         on_cnt_reg <= 32'h0000_0000;
      end else if (muting_active) begin
         on_cnt_reg <= on_cnt_reg + 32'h0000_0001;
      end else begin
         on_cnt_reg <= 32'h0000_0000;
      end
   end
   sequence pair_seen_s;
      $past(pair_in | pair_out);
   endsequence
   forced_high_a: assert property (muting_active |-> muted_out) else $error("output low while muting");
   follow_curtain_a: assert property (!muting_active && !$past(muting_active) && !cfg_blind_on && !$past(reset)
      |-> muted_out == $past(curtain_in)) else $error("output does not follow curtain");
   pair_start_a: assert property ($rose(muting_active) |-> pair_seen_s) else $error("muting without pair");
   tee_end_a: assert property (cfg_mode == `MSC_MODE_T && muting_active && !pair_in |=> !muting_active)
      else $error("T muting kept after release");
   enable_fall_a: assert property (cfg_with_enable && cfg_enable_type == `MSC_EN_DISABLE && $fell(enable_in)
      |=> !muting_active) else $error("enable fall did not cancel");
   timeout_cap_a: assert property (!cfg_timeout_unlimited |-> on_cnt_reg <= cfg_timeout_ticks * TICK_DIV + TICK_DIV)
      else $error("muting outlived timeout");
   curtain_close_a: assert property (cfg_mode == `MSC_MODE_CONC && !cfg_sensor_close && muting_active
      && $rose(curtain_in) |=> !muting_active) else $error("curtain rise did not close");
   blind_hold_a: assert property ($fell(muting_active) && cfg_blind_on && !cfg_sensor_close |-> muted_out [*8])
      else $error("blind time not held");
endmodule
bind msc_muting msc_muting_props #(.TICK_DIV(TICK_DIV)) u_props (.*);

// *** test/tb.sv ***
// Self-checking bench for the muting sequence controller.
`timescale 1ns/1ps
`include "msc_regs.vh"
module tb;
   // ----------------------------------------
   // Stimulus and instances
   // ----------------------------------------
   localparam TICK_DIV = 20;
   reg clk_sys = 1'b0;
   reg reset = 1'b1;
   reg [1:0] cfg_mode = `MSC_MODE_CONC;
   reg [1:0] cfg_direction = `MSC_DIR_UP;
   reg cfg_with_enable = 1'b0;
   reg cfg_enable_type = `MSC_EN_DISABLE;
   reg cfg_sensor_close = 1'b0;
   reg cfg_blind_on = 1'b0;
   reg cfg_min_sensor_on = 1'b0;
   reg cfg_timeout_unlimited = 1'b0;
   reg [15:0] cfg_timeout_ticks = 16'h0032;
   reg [15:0] cfg_sensor_ticks = 16'h0005;
   reg [15:0] cfg_end_ticks = 16'h0004;
   reg [15:0] cfg_blind_ticks = 16'h0003;
   reg enable_in = 1'b0;
   reg [4:0] scene = 5'h01;
   wire entry_sensor_a, entry_sensor_b, exit_sensor_a, exit_sensor_b, curtain_in;
   wire muted_out, muting_active;
   wire [5:0] state_out;
   integer err_count = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer d;
   always #25 clk_sys = ~clk_sys;
   msc_field u_field (.*);
   msc_muting #(.TICK_DIV(TICK_DIV)) u_dut (.*);
   task wrap_up;
      begin
         $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         wrap_up;
      end
   end
   task cmp(input [5:0] got, input [5:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %b, want %b", $time, got, exp);
         end
      end
   endtask
   // Called at a falling edge and returns at one, so inputs never move on the sampling edge.
   task step(input [4:0] v, input integer n);
      begin
         scene = v;
         repeat (n) @(negedge clk_sys);
      end
   endtask
   task mute;
      begin
         step(5'h01, 3);
         step(5'h11, 3);
         step(5'h19, 3);
      end
   endtask
   task try_pair(input [4:0] pre, input [4:0] a, input [4:0] b, input integer gap, input exp);
      begin
         step(pre, 3);
         step(a, gap);
         step(b, 3);
         cmp(muting_active, exp);
         step(b & 5'h1E, 3);
         step(5'h01, 4);
         cmp(muting_active, 1'b0);
      end
   endtask
   initial begin
      repeat (20) @(negedge clk_sys);
      reset = 1'b0;
      cmp(state_out, 6'h01);
      try_pair(5'h01, 5'h11, 5'h19, 3, 1'b1);
      try_pair(5'h01, 5'h09, 5'h19, 3, 1'b1);
      mute;
      step(5'h18, 3);
      cmp(muted_out, 1'b1);
      step(5'h00, 3);
      cmp(muting_active, 1'b1);
      step(5'h01, 4);
      step(5'h00, 3);
      cmp(muted_out, 1'b0);
      $display("test basic done");
      try_pair(5'h01, 5'h11, 5'h19, 7 * TICK_DIV, 1'b0);
      try_pair(5'h01, 5'h11, 5'h19, 3 * TICK_DIV, 1'b1);
      try_pair(5'h00, 5'h10, 5'h18, 3, 1'b0);
      try_pair(5'h03, 5'h13, 5'h1B, 3, 1'b0);
      $display("test timing done");
      for (d = 0; d < 3; d = d + 1) begin
         cfg_direction = d;
         try_pair(5'h01, 5'h05, 5'h07, 3, d != `MSC_DIR_UP);
         try_pair(5'h01, 5'h11, 5'h19, 3, d != `MSC_DIR_DOWN);
      end
      cfg_direction = `MSC_DIR_UP;
      cfg_min_sensor_on = 1'b1;
      cfg_sensor_ticks = 16'h0019;
      try_pair(5'h01, 5'h11, 5'h19, 3, 1'b0);
      try_pair(5'h01, 5'h11, 5'h19, 17 * TICK_DIV, 1'b1);
      cfg_min_sensor_on = 1'b0;
      cfg_sensor_ticks = 16'h0005;
      $display("test direction done");
      cfg_with_enable = 1'b1;
      try_pair(5'h01, 5'h11, 5'h19, 3, 1'b0);
      enable_in = 1'b1;
      try_pair(5'h01, 5'h11, 5'h19, 3, 1'b1);
      try_pair(5'h01, 5'h11, 5'h19, 3, 1'b0);
      enable_in = 1'b0;
      step(5'h01, 3);
      enable_in = 1'b1;
      mute;
      enable_in = 1'b0;
      step(5'h19, 2);
      cmp(muting_active, 1'b0);
      cfg_enable_type = `MSC_EN_ONLY;
      step(5'h01, 4);
      enable_in = 1'b1;
      mute;
      enable_in = 1'b0;
      step(5'h19, 3);
      cmp(muting_active, 1'b1);
      step(5'h18, 3);
      step(5'h01, 4);
      cfg_with_enable = 1'b0;
      $display("test enable done");
      mute;
      step(5'h19, 50 * TICK_DIV - 40);
      cmp(muting_active, 1'b1);
      step(5'h19, 60);
      cmp(muting_active, 1'b0);
      step(5'h01, 4);
      cfg_sensor_close = 1'b1;
      mute;
      step(5'h1F, 3);
      step(5'h07, 3);
      cmp(muting_active, 1'b1);
      step(5'h03, 3);
      cmp(muting_active, 1'b0);
      step(5'h01, 4);
      cfg_sensor_close = 1'b0;
      cfg_blind_on = 1'b1;
      mute;
      step(5'h18, 3);
      step(5'h01, 3);
      step(5'h00, 3);
      cmp(muted_out, 1'b1);
      step(5'h00, 5 * TICK_DIV);
      cmp(muted_out, 1'b0);
      step(5'h01, 3);
      cfg_blind_on = 1'b0;
      $display("test closing done");
      cfg_mode = `MSC_MODE_L;
      mute;
      step(5'h09, 2 * TICK_DIV);
      cmp(muting_active, 1'b1);
      step(5'h09, 4 * TICK_DIV);
      cmp(muting_active, 1'b0);
      mute;
      step(5'h01, 3);
      cmp(muting_active, 1'b0);
      cfg_mode = `MSC_MODE_T;
      mute;
      step(5'h11, 2);
      cmp(muting_active, 1'b0);
      cfg_mode = `MSC_MODE_SEQ;
      for (d = 0; d < 3; d = d + 1) begin
         cfg_direction = d;
         try_pair(5'h01, 5'h11, 5'h19, 3, d != `MSC_DIR_DOWN);
         try_pair(5'h01, 5'h03, 5'h07, 3, d != `MSC_DIR_UP);
      end
      cfg_direction = `MSC_DIR_UP;
      try_pair(5'h01, 5'h09, 5'h19, 3, 1'b0);
      $display("test variants done");
      wrap_up;
   end
endmodule
